/* File: design/dpsc_core.sv */
// serial slave command decoder for a dual 64 tap potentiometer
// Behaviour
// - one of 64 switches closed per array
// - wiper register volatile, written or copied
// - respond only when type code matches
// - low address bits must match straps
// - stop starts nv write, inputs disabled
// - no address ack while nv write busy
// - opcode, register select, pot select fields
// - two byte transfer instructions, no data
// - stored to wiper copy is volatile write
// - wiper to stored copy is nv write
// - single and global transfer forms
// - read/write wiper and stored registers
// - data high pulse steps toward high terminal
// - data low pulse steps toward low terminal
// - wiper read returns 00 plus position
// - wiper write takes 00 plus position
// - pot select zero first, one second
// - stored read uses pot and register select
// - stored write starts nv cycle after stop
// - step bit one increments, zero decrements
// - write protect low blocks nv writes
// - ack address, instruction and data byte
// - reset loads wiper from stored register zero
// - nv write finishes within 10 ms
`timescale 1ns/1ps
module dpsc_core #(
	parameter int NVW_CYC = dpsc_pkg::DPSC_NVW_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// serial bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// straps and protection
	input wire logic [3:0] addr_strap_pins,
	input wire logic write_protect_n,
	// tap switches and status
	output logic [63:0] tap_sw0,
	output logic [63:0] tap_sw1,
	output logic [5:0] wiper_out0,
	output logic [5:0] wiper_out1,
	output logic nv_busy
);
	import dpsc_pkg::*;

	typedef enum logic [2:0] {S_IDLE, S_ADDR, S_INSTR, S_DATA, S_READ, S_STEP, S_IGNORE}
		dpsc_phase_t;

	// all block state
	typedef struct packed {
		logic [1:0] scl_sy;
		logic [1:0] sda_sy;
		logic scl_d;
		logic sda_d;
		dpsc_phase_t ph;
		logic [3:0] bitc;
		logic [7:0] sh;
		logic [7:0] instr;
		logic ack;
		logic drive;
		logic drv_val;
		logic step_ok;
		logic [5:0] wpr0;
		logic [5:0] wpr1;
		logic [5:0] wout0;
		logic [5:0] wout1;
		logic [7:0] wrl_cnt;
		logic [7:0] ssr0_0;
		logic [7:0] ssr0_1;
		logic [7:0] ssr0_2;
		logic [7:0] ssr0_3;
		logic [7:0] ssr1_0;
		logic [7:0] ssr1_1;
		logic [7:0] ssr1_2;
		logic [7:0] ssr1_3;
		logic nv_pend;
		logic nv_glob;
		logic nv_fromw;
		logic [7:0] nv_data;
		logic [2:0] nv_sel;
		logic [31:0] nv_cnt;
		logic boot;
	} dpsc_state_t;

	dpsc_state_t st_ff;
	dpsc_state_t nxt_st;
	dpsc_tap_if tap ();

	// stored setting register read by flat index {pot, reg}
	function automatic logic [7:0] ssr_get(input dpsc_state_t s, input logic [2:0] i);
		case (i)
			3'h0: ssr_get = s.ssr0_0;
			3'h1: ssr_get = s.ssr0_1;
			3'h2: ssr_get = s.ssr0_2;
			3'h3: ssr_get = s.ssr0_3;
			3'h4: ssr_get = s.ssr1_0;
			3'h5: ssr_get = s.ssr1_1;
			3'h6: ssr_get = s.ssr1_2;
			default: ssr_get = s.ssr1_3;
		endcase
	endfunction

	// stored setting register write by flat index
	function automatic dpsc_state_t ssr_put(input dpsc_state_t s, input logic [2:0] i,
			input logic [7:0] v);
		ssr_put = s;
		case (i)
			3'h0: ssr_put.ssr0_0 = v;
			3'h1: ssr_put.ssr0_1 = v;
			3'h2: ssr_put.ssr0_2 = v;
			3'h3: ssr_put.ssr0_3 = v;
			3'h4: ssr_put.ssr1_0 = v;
			3'h5: ssr_put.ssr1_1 = v;
			3'h6: ssr_put.ssr1_2 = v;
			default: ssr_put.ssr1_3 = v;
		endcase
	endfunction

	// decoded bus events, all from synchronised copies
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic [3:0] opc;
	logic [2:0] sel;
	logic pot;

	always_comb begin
		scl_rise = st_ff.scl_sy[1] & ~st_ff.scl_d;
		scl_fall = ~st_ff.scl_sy[1] & st_ff.scl_d;
		bus_start = st_ff.scl_sy[1] & st_ff.scl_d & st_ff.sda_d & ~st_ff.sda_sy[1];
		bus_stop = st_ff.scl_sy[1] & st_ff.scl_d & ~st_ff.sda_d & st_ff.sda_sy[1];
		opc = st_ff.instr[DPSC_OPC_HI:DPSC_OPC_LO];
		pot = st_ff.instr[DPSC_POT_BIT];
		sel = {pot, st_ff.instr[DPSC_RSEL_HI:DPSC_RSEL_LO]};
	end

	// next state of the whole block
	always_comb begin
		nxt_st = st_ff;
		// two flip-flop synchronisers, then edge history
		nxt_st.scl_sy = {st_ff.scl_sy[0], scl_in};
		nxt_st.sda_sy = {st_ff.sda_sy[0], sda_in};
		nxt_st.scl_d = st_ff.scl_sy[1];
		nxt_st.sda_d = st_ff.sda_sy[1];
		// power-up restore of each wiper from its register zero
		if (st_ff.boot) begin
			nxt_st.boot = 1'b0;
			nxt_st.wpr0 = st_ff.ssr0_0[5:0];
			nxt_st.wpr1 = st_ff.ssr1_0[5:0];
		end
		// wiper output follows the register after the response delay
		if (st_ff.wout0 != st_ff.wpr0 || st_ff.wout1 != st_ff.wpr1) begin
			if (st_ff.wrl_cnt >= 8'(DPSC_WRL_CYC - 1)) begin
				nxt_st.wout0 = st_ff.wpr0;
				nxt_st.wout1 = st_ff.wpr1;
				nxt_st.wrl_cnt = 8'h00;
			end else begin
				nxt_st.wrl_cnt = st_ff.wrl_cnt + 8'h01;
			end
		end else begin
			nxt_st.wrl_cnt = 8'h00;
		end
		// nonvolatile write timer; commits at the end of the cycle
		if (st_ff.nv_cnt != 32'h0000_0000) begin
			nxt_st.nv_cnt = st_ff.nv_cnt - 32'h0000_0001;
			if (st_ff.nv_cnt == 32'h0000_0001) begin
				if (st_ff.nv_glob) begin
					// global form writes both pots at one register index
					nxt_st = ssr_put(nxt_st, {1'b0, st_ff.nv_sel[1:0]},
						{2'b00, st_ff.wpr0});
					nxt_st = ssr_put(nxt_st, {1'b1, st_ff.nv_sel[1:0]}, {2'b00, st_ff.wpr1});
				end else if (st_ff.nv_fromw) begin
					nxt_st = ssr_put(nxt_st, st_ff.nv_sel,
						{2'b00, st_ff.nv_sel[2] ? st_ff.wpr1 : st_ff.wpr0});
				end else begin
					nxt_st = ssr_put(nxt_st, st_ff.nv_sel, st_ff.nv_data);
				end
			end
		end else begin
			// inputs ignored while busy: the bus decoding below runs only when no nv write is busy
			if (bus_stop) begin
				nxt_st.ph = S_IDLE;
				nxt_st.drive = 1'b0;
				if (st_ff.nv_pend && write_protect_n) begin
					nxt_st.nv_cnt = 32'(NVW_CYC);
				end
				nxt_st.nv_pend = 1'b0;
			end else if (bus_start) begin
				nxt_st.ph = S_ADDR;
				nxt_st.bitc = 4'h0;
				nxt_st.drive = 1'b0;
				nxt_st.ack = 1'b0;
				nxt_st.nv_pend = 1'b0;
			end else if (scl_rise) begin
				case (st_ff.ph)
					S_ADDR, S_INSTR, S_DATA, S_READ: begin
						// rise k of a byte sees bitc == k; the read shifter is ours alone
						if (st_ff.bitc != 4'h0 && st_ff.bitc < 4'h9 && st_ff.ph != S_READ)
							nxt_st.sh = {st_ff.sh[6:0], st_ff.sda_sy[1]};
						else if (st_ff.ph == S_READ && st_ff.bitc == 4'h9 && st_ff.sda_sy[1])
							nxt_st.ph = S_IGNORE; // master nack ends a read
					end
					S_STEP: begin
						if (st_ff.step_ok) begin
							if (st_ff.sda_sy[1]) begin
								if (pot) begin
									if (st_ff.wpr1 != DPSC_POS_MAX) nxt_st.wpr1 = st_ff.wpr1 + 6'h01;
								end else if (st_ff.wpr0 != DPSC_POS_MAX) begin
									nxt_st.wpr0 = st_ff.wpr0 + 6'h01;
								end
							end else begin
								if (pot) begin
									if (st_ff.wpr1 != 6'h00) nxt_st.wpr1 = st_ff.wpr1 - 6'h01;
								end else if (st_ff.wpr0 != 6'h00) begin
									nxt_st.wpr0 = st_ff.wpr0 - 6'h01;
								end
							end
						end
					end
					default: begin
					end
				endcase
			end else if (scl_fall) begin
				nxt_st.step_ok = (st_ff.ph == S_STEP);
				case (st_ff.ph)
					S_ADDR, S_INSTR, S_DATA, S_READ: begin
						nxt_st.bitc = st_ff.bitc + 4'h1;
						nxt_st.drive = 1'b0;
						if (st_ff.bitc == 4'h8 && st_ff.ph != S_READ) begin
							// ack slot after a received byte
							nxt_st.drive = 1'b1;
							nxt_st.drv_val = 1'b0;
							if (st_ff.ph == S_ADDR &&
									(st_ff.sh[7:4] != DPSC_TYPE_CODE ||
									st_ff.sh[3:0] != addr_strap_pins)) begin
								nxt_st.drive = 1'b0;
								nxt_st.ph = S_IGNORE;
							end
						end else if (st_ff.bitc == 4'h9) begin
							// the fall ending the ack slot is also the first fall of the next byte
							nxt_st.bitc = 4'h1;
							case (st_ff.ph)
								S_ADDR: nxt_st.ph = S_INSTR;
								S_INSTR: begin
									nxt_st.instr = st_ff.sh;
									nxt_st.ph = S_IGNORE;
									case (st_ff.sh[DPSC_OPC_HI:DPSC_OPC_LO])
										OP_WR_WPR, OP_WR_SSR: nxt_st.ph = S_DATA;
										OP_RD_WPR, OP_RD_SSR: begin
											nxt_st.ph = S_READ;
											nxt_st.sh = (st_ff.sh[DPSC_OPC_HI:DPSC_OPC_LO] == OP_RD_WPR)
												? {2'b00, st_ff.sh[0] ? st_ff.wpr1 : st_ff.wpr0}
												: ssr_get(st_ff, {st_ff.sh[0], st_ff.sh[3:2]});
											nxt_st.drive = 1'b1;
										end
										OP_STEP: begin
											nxt_st.ph = S_STEP;
											nxt_st.step_ok = 1'b1;
										end
										OP_XFR_S2W: begin
											if (st_ff.sh[0])
												nxt_st.wpr1 = 6'(ssr_get(st_ff, {1'b1, st_ff.sh[3:2]}));
											else
												nxt_st.wpr0 = 6'(ssr_get(st_ff, {1'b0, st_ff.sh[3:2]}));
										end
										OP_GXFR_S2W: begin
											nxt_st.wpr0 = 6'(ssr_get(st_ff, {1'b0, st_ff.sh[3:2]}));
											nxt_st.wpr1 = 6'(ssr_get(st_ff, {1'b1, st_ff.sh[3:2]}));
										end
										OP_XFR_W2S, OP_GXFR_W2S: begin
											nxt_st.nv_pend = 1'b1;
											nxt_st.nv_fromw = 1'b1;
											nxt_st.nv_glob = (st_ff.sh[DPSC_OPC_HI:DPSC_OPC_LO] == OP_GXFR_W2S);
											nxt_st.nv_sel = {st_ff.sh[0], st_ff.sh[3:2]};
										end
										default: begin
										end
									endcase
								end
								S_DATA: begin
									nxt_st.ph = S_IGNORE;
									if (opc == OP_WR_WPR) begin
										if (pot) nxt_st.wpr1 = st_ff.sh[5:0];
										else nxt_st.wpr0 = st_ff.sh[5:0];
									end else begin
										nxt_st.nv_pend = 1'b1;
										nxt_st.nv_fromw = 1'b0;
										nxt_st.nv_glob = 1'b0;
										nxt_st.nv_sel = sel;
										nxt_st.nv_data = st_ff.sh;
									end
								end
								S_READ: nxt_st.ph = S_IGNORE;
								default: nxt_st.ph = S_IGNORE;
							endcase
						end
						if (st_ff.ph == S_READ && st_ff.bitc != 4'h0 && st_ff.bitc < 4'h8) begin
							nxt_st.drive = 1'b1;
							nxt_st.sh = {st_ff.sh[6:0], 1'b0};
						end
					end
					default: begin
					end
				endcase
			end
			// read data bit on the line follows the shifter msb
			if (nxt_st.ph == S_READ && nxt_st.bitc < 4'h9)
				nxt_st.drv_val = nxt_st.sh[7];
		end
		// busy address phase is simply never acknowledged
	end

	// single registered state update
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_ff <= '0;
			st_ff.scl_sy <= 2'b11;
			st_ff.sda_sy <= 2'b11;
			st_ff.scl_d <= 1'b1;
			st_ff.sda_d <= 1'b1;
			st_ff.ph <= S_IDLE;
			st_ff.ssr0_0 <= DPSC_SSR_RESET;
			st_ff.ssr1_0 <= DPSC_SSR_RESET;
			st_ff.boot <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tap.pos0 = st_ff.wout0;
	assign tap.pos1 = st_ff.wout1;
	dpsc_tap_decode u_dec (
		.tap(tap.dec)
	);

	// open-drain: only ever pull low
	always_comb begin
		sda_out = 1'b0;
		sda_oe = st_ff.drive & ~st_ff.drv_val;
		tap_sw0 = tap.tap0;
		tap_sw1 = tap.tap1;
		wiper_out0 = st_ff.wout0;
		wiper_out1 = st_ff.wout1;
		nv_busy = (st_ff.nv_cnt != 32'h0000_0000);
	end
endmodule

/* File: design/dpsc_pkg.sv */
// package of constants for the dual pot serial command block
package dpsc_pkg;
	localparam int DPSC_CLK_MHZ = 100;
	localparam int DPSC_NVW_MS = 10;
	localparam int DPSC_NVW_CYC = DPSC_NVW_MS * 1000 * DPSC_CLK_MHZ;
	localparam int DPSC_WRL_NS = 100;
	localparam int DPSC_WRL_CYC = (DPSC_WRL_NS * DPSC_CLK_MHZ + 999) / 1000;
	// device type code; the value is arbitrary
	localparam logic [3:0] DPSC_TYPE_CODE = 4'h0;
	localparam logic [3:0] OP_RD_WPR = 4'h9;
	localparam logic [3:0] OP_WR_WPR = 4'hA;
	localparam logic [3:0] OP_RD_SSR = 4'hB;
	localparam logic [3:0] OP_WR_SSR = 4'hC;
	localparam logic [3:0] OP_XFR_S2W = 4'hD;
	localparam logic [3:0] OP_XFR_W2S = 4'hE;
	localparam logic [3:0] OP_GXFR_S2W = 4'h1;
	localparam logic [3:0] OP_GXFR_W2S = 4'h8;
	localparam logic [3:0] OP_STEP = 4'h2;
	localparam logic [5:0] DPSC_POS_MAX = 6'h3F;
	localparam logic [7:0] DPSC_SSR_RESET = 8'h00;
	localparam int DPSC_OPC_HI = 7;
	localparam int DPSC_OPC_LO = 4;
	localparam int DPSC_RSEL_HI = 3;
	localparam int DPSC_RSEL_LO = 2;
	localparam int DPSC_POT_BIT = 0;
endpackage

/* File: design/dpsc_tap_decode.sv */
// one-hot tap switch decoder for both resistor arrays
`timescale 1ns/1ps
module dpsc_tap_decode (
	// wiper positions in, switches out
	dpsc_tap_if.dec tap
);
	// exactly one switch per array is closed
	function automatic logic [63:0] onehot(input logic [5:0] p);
		onehot = 64'h0000_0000_0000_0001 << p;
	endfunction
	always_comb begin
		tap.tap0 = onehot(tap.pos0);
		tap.tap1 = onehot(tap.pos1);
	end
endmodule

/* File: design/dpsc_tap_if.sv */
// interface carrying wiper positions to the tap decoder
`timescale 1ns/1ps
interface dpsc_tap_if;
	logic [5:0] pos0;
	logic [5:0] pos1;
	logic [63:0] tap0;
	logic [63:0] tap1;
	modport ctl (output pos0, output pos1, input tap0, input tap1);
	modport dec (input pos0, input pos1, output tap0, output tap1);
endinterface

/* File: verif/dpsc_chk.sv */
// assertion checker for the serial pot command block
`timescale 1ns/1ps
module dpsc_chk #(
	parameter int NVW_CYC = 50
) (
	// clock and reset
	input logic clk_sys,
	input logic reset,
	// serial pins
	input logic scl_in,
	input logic sda_in,
	input logic sda_out,
	input logic sda_oe,
	// straps and protection
	input logic [3:0] addr_strap_pins,
	input logic write_protect_n,
	// pot outputs
	input logic [63:0] tap_sw0,
	input logic [63:0] tap_sw1,
	input logic [5:0] wiper_out0,
	input logic [5:0] wiper_out1,
	input logic nv_busy
);
	int busy_ff; // cycles of the current write
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	// count write cycles; cleared when idle so each write starts at zero
	always_ff @(posedge clk_sys) begin
		busy_ff <= (reset || !nv_busy) ? 0 : busy_ff + 1;
	end
	// a write cycle begins
	sequence s_nvw_go;
		!nv_busy ##1 nv_busy;
	endsequence
	a_tap_one0: assert property ($onehot(tap_sw0)) else $error("tap 0 not one-hot");
	a_tap_one1: assert property ($onehot(tap_sw1)) else $error("tap 1 not one-hot");
	a_rst_state: assert property ($fell(reset) |-> !sda_oe && tap_sw0 == 64'h1)
		else $error("bad state after reset");
	a_ack_low: assert property ($rose(sda_oe) |-> !$past(scl_in, 2))
		else $error("data pulled in clock high");
	a_sda_zero: assert property (sda_out == 1'b0) else $error("data driven high");
	a_busy_nack: assert property (nv_busy && $past(nv_busy) |-> !sda_oe)
		else $error("ack during write");
	a_busy_hold: assert property (s_nvw_go |=> nv_busy [*8]) else $error("write short");
	a_busy_len: assert property ($fell(nv_busy) |-> busy_ff == NVW_CYC)
		else $error("write length wrong");
	a_wp_block: assert property (s_nvw_go |-> $past(write_protect_n, 2))
		else $error("write while protected");
	a_wiper_hold: assert property (nv_busy |=> $stable(wiper_out0))
		else $error("wiper moved in write");
endmodule
bind dpsc_core dpsc_chk #(.NVW_CYC(NVW_CYC)) chk (.clk_sys(clk_sys), .reset(reset),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.addr_strap_pins(addr_strap_pins), .write_protect_n(write_protect_n),
	.tap_sw0(tap_sw0), .tap_sw1(tap_sw1), .wiper_out0(wiper_out0),
	.wiper_out1(wiper_out1), .nv_busy(nv_busy));

/* File: verif/dpsc_core_tb.sv */
// self-checking bench for the serial pot command block
`timescale 1ns/1ps
module dpsc_core_tb;
	import dpsc_pkg::*;
	logic clk_sys, reset, scl, sda, sda_oe, nv_busy, wp_n, a;
	logic [3:0] strap;
	logic [63:0] tap0, tap1;
	logic [5:0] w0, w1;
	logic [7:0] d;
	int fail_count, samples_checked, cyc, n;
	dpsc_twm m (.clk_sys(clk_sys), .scl(scl), .sda(sda), .sda_oe(sda_oe));
	dpsc_core #(.NVW_CYC(400)) uut (.clk_sys(clk_sys), .reset(reset), .scl_in(scl),
		.sda_in(sda), .sda_out(), .sda_oe(sda_oe), .addr_strap_pins(strap),
		.write_protect_n(wp_n), .tap_sw0(tap0), .tap_sw1(tap1), .wiper_out0(w0),
		.wiper_out1(w1), .nv_busy(nv_busy));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task chk(input string s, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s exp %h got %h", s, e, g);
		end
	endtask
	task test_done;
		if (fail_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// hang guard, well above the expected run length
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc > 30000) begin
			fail_count++;
			test_done();
		end
	end
	// address only, then stop; returns the ack
	task adr(input logic [7:0] b);
		m.edge2(1'b1);
		m.wbyte(b, a);
		m.edge2(1'b0);
	endtask
	// command with optional data byte; every byte must be acked
	task wr(input logic [7:0] ins, input logic [7:0] v, input logic nd);
		logic b, c;
		m.edge2(1'b1);
		m.wbyte({DPSC_TYPE_CODE, strap}, a);
		m.wbyte(ins, b);
		c = 1'b1;
		if (nd) m.wbyte(v, c);
		m.edge2(1'b0);
		chk("ack", 1'b1, a & b & c);
		m.w(20);
	endtask
	task rd(input logic [7:0] ins, input logic [7:0] e);
		logic b;
		m.edge2(1'b1);
		m.wbyte({DPSC_TYPE_CODE, strap}, a);
		m.wbyte(ins, b);
		m.rbyte(1'b1, d);
		m.edge2(1'b0);
		chk("read", e, d);
	endtask
	// poll the address until acked; a busy device must refuse first
	task poll;
		n = 0;
		a = 1'b0;
		while (!a && n < 40) begin
			adr({DPSC_TYPE_CODE, strap});
			n++;
		end
		chk("polls", 8'h1, 8'(n > 1));
		chk("busy", 1'b0, nv_busy);
	endtask
	initial begin
		reset = 1'b1;
		wp_n = 1'b1;
		strap = 4'hA;
		repeat (16) @(posedge clk_sys);
		reset <= 1'b0;
		m.w(6);
		chk("w0 reset", 8'h0, {2'b00, w0});
		chk("tap0 reset", 8'h1, tap0[7:0]);
		wr({OP_WR_WPR, 4'h0}, 8'h2A, 1'b1);
		wr({OP_WR_WPR, 4'h1}, 8'h15, 1'b1);
		chk("w0", 8'h2A, {2'b00, w0});
		chk("w1", 8'h15, {2'b00, w1});
		rd({OP_RD_WPR, 4'h1}, 8'h15);
		adr({DPSC_TYPE_CODE ^ 4'h1, strap});
		chk("type nack", 1'b0, a);
		adr({DPSC_TYPE_CODE, strap ^ 4'h8});
		chk("strap nack", 1'b0, a);
		strap <= 4'h5;
		wr({OP_WR_WPR, 4'h0}, 8'h2A, 1'b1);
		rd({OP_RD_WPR, 4'h0}, 8'h2A);
		strap <= 4'hA;
		wr({OP_WR_SSR, 4'b1001}, 8'h33, 1'b1);
		chk("busy", 1'b1, nv_busy);
		poll();
		rd({OP_RD_SSR, 4'b1001}, 8'h33);
		wr({OP_XFR_S2W, 4'b1001}, 8'h0, 1'b0);
		chk("w1 xfer", 8'h33, {2'b00, w1});
		wr({OP_XFR_W2S, 4'b0100}, 8'h0, 1'b0);
		poll();
		rd({OP_RD_SSR, 4'b0100}, 8'h2A);
		wp_n <= 1'b0;
		wr({OP_WR_SSR, 4'b0100}, 8'h11, 1'b1);
		chk("busy wp", 1'b0, nv_busy);
		wp_n <= 1'b1;
		rd({OP_RD_SSR, 4'b0100}, 8'h2A);
		wr({OP_GXFR_S2W, 4'b1000}, 8'h0, 1'b0);
		chk("w0 glob", 8'h0, {2'b00, w0});
		chk("w1 glob", 8'h33, {2'b00, w1});
		wr({OP_GXFR_W2S, 4'b1100}, 8'h0, 1'b0);
		poll();
		rd({OP_RD_SSR, 4'b1101}, 8'h33);
		m.edge2(1'b1);
		m.wbyte({DPSC_TYPE_CODE, strap}, a);
		m.wbyte({OP_STEP, 4'h0}, a);
		m.bitx(1'b0, a);
		repeat (64) m.bitx(1'b1, a);
		m.bitx(1'b0, a);
		m.edge2(1'b0);
		m.w(20);
		// the stop's own clock pulse with data low is one more step down
		chk("w0 step", 8'h3D, {2'b00, w0});
		test_done();
	end
endmodule

/* File: verif/dpsc_twm.sv */
// two-wire bus master model for the serial pins
`timescale 1ns/1ps
module dpsc_twm (
	// clock
	input logic clk_sys,
	// bus pins
	output logic scl,
	output logic sda,
	input logic sda_oe
);
	logic pull; // master holds the line low
	// pull-up: line floats high unless a side pulls it
	assign sda = !(pull || sda_oe);
	initial begin
		scl = 1'b1;
		pull = 1'b0;
	end
	task w(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// 80 ns bit: long low phase so the slave releases before our rise
	task bitx(input logic b, output logic r);
		scl <= 1'b0;
		w(2);
		pull <= !b;
		w(3);
		scl <= 1'b1;
		w(1);
		r = sda;
		w(2);
	endtask
	// p=1 start, p=0 stop; clock then stands high
	task edge2(input logic p);
		scl <= 1'b0;
		w(5);
		pull <= !p;
		w(3);
		scl <= 1'b1;
		w(4);
		pull <= p;
		w(4);
	endtask
	// byte out msb first, returns slave ack
	task wbyte(input logic [7:0] d, output logic a);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(d[i], r);
		bitx(1'b1, r);
		a = !r;
	endtask
	// byte in msb first, then master ack
	task rbyte(input logic master_acknowledge, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
		bitx(!master_acknowledge, r);
	endtask
endmodule
